// ---- rtl/acr_params.svh ----
// Constants of the serial configuration register bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_NUM_SLOTS 32
`define ACR_REG_RESET 8'h00
`define ACR_CNT_READ_START 4'h8
`define ACR_CNT_LAST_BIT 4'hF

// Field positions
`define ACR_BIT_READBACK 0
`define ACR_BIT_SOFT_RESET 1
`define ACR_SWING_MSB 7
`define ACR_SWING_LSB 2
`define ACR_UNLOCK_MSB 1
`define ACR_UNLOCK_LSB 0
`define ACR_UNLOCK_KEY 2'h3
`define ACR_SWING_DEFAULT 6'h00
`define ACR_PDN_MSB 3
`define ACR_PDN_LSB 0
`define ACR_GLOBAL_PDN_BIT 2

// Drive levels in mV
`define ACR_MV_350 10'h15E
`define ACR_MV_420 10'h1A4
`define ACR_MV_470 10'h1D6
`define ACR_MV_560 10'h230
`define ACR_MV_160 10'h0A0

// Register offsets
`define ACR_ADDR_SOFT_RESET_AND_READBACK 8'h00
`define ACR_ADDR_OUTPUT_DRIVE_LEVEL 8'h01
`define ACR_ADDR_CHAN_B_GAIN_AND_PATTERN 8'h25
`define ACR_ADDR_CHAN_A_GAIN_AND_PATTERN 8'h2B
`define ACR_ADDR_CHAN_D_GAIN_AND_PATTERN 8'h31
`define ACR_ADDR_CHAN_C_GAIN_AND_PATTERN 8'h37
`define ACR_ADDR_OFFSET_CORRECTION_SELECT 8'h3D
`define ACR_ADDR_USER_PATTERN_HIGH 8'h3F
`define ACR_ADDR_USER_PATTERN_LOW 8'h40
`define ACR_ADDR_BURST_HIGH_RES_COUNT 8'h41
`define ACR_ADDR_PROCESSING_ENABLE_LOW_RES 8'h42
`define ACR_ADDR_BURST_MODE_PAIR_ENABLES 8'h44
`define ACR_ADDR_OVERRANGE_AND_GLOBAL_PD 8'h45
`define ACR_ADDR_FACTORY_SETTING_4A 8'h4A
`define ACR_ADDR_FACTORY_SETTING_62 8'h62
`define ACR_ADDR_FACTORY_SETTING_7A 8'h7A
`define ACR_ADDR_FACTORY_SETTING_92 8'h92
`define ACR_ADDR_OUTPUT_CLOCK_DELAY_PAIR1 8'hA9
`define ACR_ADDR_OUTPUT_CLOCK_DELAY_PAIR2 8'hAC
`define ACR_ADDR_QUICK_OVERRANGE_LEVEL 8'hC3
`define ACR_ADDR_QUICK_OVERRANGE_ENABLE 8'hC4
`define ACR_ADDR_FACTORY_SETTING_CF 8'hCF
`define ACR_ADDR_FACTORY_SETTING_D4 8'hD4
`define ACR_ADDR_FACTORY_SETTING_D5 8'hD5
`define ACR_ADDR_FACTORY_SETTING_D6 8'hD6
`define ACR_ADDR_FACTORY_SETTING_D7 8'hD7
`define ACR_ADDR_FACTORY_SETTING_DB 8'hDB
`define ACR_ADDR_BOOST_PIN_OVERRIDE 8'hEA
`define ACR_ADDR_FACTORY_SETTING_F0 8'hF0
`define ACR_ADDR_DRIVE_LEVEL_UNLOCK 8'hF1
`define ACR_ADDR_FACTORY_SETTING_F5 8'hF5
`define ACR_ADDR_PER_CHANNEL_POWER_DOWN 8'hFE

// Writable bits per register, all others held at zero
`define ACR_MASK_SOFT_RESET_AND_READBACK 8'h01
`define ACR_MASK_OUTPUT_DRIVE_LEVEL 8'hFC
`define ACR_MASK_FULL_BYTE 8'hFF
`define ACR_MASK_OFFSET_CORRECTION_SELECT 8'h20
`define ACR_MASK_USER_PATTERN_HIGH 8'h3F
`define ACR_MASK_BURST_HIGH_RES_COUNT 8'h1F
`define ACR_MASK_PROCESSING_ENABLE_LOW_RES 8'h0F
`define ACR_MASK_BURST_MODE_PAIR_ENABLES 8'hC5
`define ACR_MASK_OVERRANGE_AND_GLOBAL_PD 8'h0D
`define ACR_MASK_BIT0_ONLY 8'h01
`define ACR_MASK_OUTPUT_CLOCK_DELAY_PAIR1 8'h0F
`define ACR_MASK_OUTPUT_CLOCK_DELAY_PAIR2 8'h78
`define ACR_MASK_BIT7_ONLY 8'h80
`define ACR_MASK_FACTORY_SETTING_CF 8'h08
`define ACR_MASK_FACTORY_SETTING_D7 8'h0C
`define ACR_MASK_FACTORY_SETTING_DB 8'h30
`define ACR_MASK_FACTORY_SETTING_F0 8'h38
`define ACR_MASK_DRIVE_LEVEL_UNLOCK 8'h23
`define ACR_MASK_FACTORY_SETTING_F5 8'h42
`define ACR_MASK_PER_CHANNEL_POWER_DOWN 8'h0F

`endif

// ---- rtl/acr_pkg.sv ----
// Types of the serial configuration register bank.
// Assumes acr_params.svh is on the include path.
`include "acr_params.svh"

package acr_pkg;
    typedef logic [7:0] acr_byte_t;
    typedef logic [4:0] acr_slot_t;
    typedef logic [9:0] acr_mv_t;

    typedef enum logic [5:0] {
        ACR_SWING_350 = 6'h00,
        ACR_SWING_420 = 6'h1B,
        ACR_SWING_470 = 6'h32,
        ACR_SWING_560 = 6'h14,
        ACR_SWING_160 = 6'h0F
    } acr_swing_e;

    typedef struct packed {
        logic hit;
        acr_slot_t slot;
        acr_byte_t mask;
    } acr_lookup_s;
endpackage

// ---- rtl/acr_config_regs.sv ----
// Configuration register bank behind a four-wire serial port.
// Assumes the serial clock comes from the host and may stop between words.
// What this block does
// - Soft reset bit restores defaults, then self-clears
// - Readback off: read-data pin not driven
// - Readback on: read-data pin driven with data
// - Drive-level field applies only when unlocked
// - Drive-level codes decode to five levels
// - Address-zero register resets to zero
// - Drive-level register resets to zero
// - Sixteen-bit words: address then data
// - Sample on falling edge while selected
// - Readback on: only address zero writable
// - Read bits change on rising edges
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_config_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_sclk,
    input wire logic port_select_low,
    input wire logic serial_write_data,
    output logic serial_read_data_pin,
    output logic serial_read_data_pin_oe,
    output logic readback_active,
    output logic [5:0] drive_level_sel,
    output acr_pkg::acr_mv_t drive_level_mv,
    output logic [3:0] chan_power_down,
    output logic global_power_down
);
    import acr_pkg::*;

    function automatic acr_lookup_s acr_lookup(input acr_byte_t addr);
        acr_lookup_s r;
        r = '{hit: 1'b0, slot: 5'h00, mask: 8'h00};
        case (addr)
            `ACR_ADDR_SOFT_RESET_AND_READBACK: r = '{1'b1, 5'h00, `ACR_MASK_SOFT_RESET_AND_READBACK};
            `ACR_ADDR_OUTPUT_DRIVE_LEVEL: r = '{1'b1, 5'h01, `ACR_MASK_OUTPUT_DRIVE_LEVEL};
            `ACR_ADDR_CHAN_B_GAIN_AND_PATTERN: r = '{1'b1, 5'h02, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_CHAN_A_GAIN_AND_PATTERN: r = '{1'b1, 5'h03, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_CHAN_D_GAIN_AND_PATTERN: r = '{1'b1, 5'h04, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_CHAN_C_GAIN_AND_PATTERN: r = '{1'b1, 5'h05, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_OFFSET_CORRECTION_SELECT: r = '{1'b1, 5'h06, `ACR_MASK_OFFSET_CORRECTION_SELECT};
            `ACR_ADDR_USER_PATTERN_HIGH: r = '{1'b1, 5'h07, `ACR_MASK_USER_PATTERN_HIGH};
            `ACR_ADDR_USER_PATTERN_LOW: r = '{1'b1, 5'h08, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_BURST_HIGH_RES_COUNT: r = '{1'b1, 5'h09, `ACR_MASK_BURST_HIGH_RES_COUNT};
            `ACR_ADDR_PROCESSING_ENABLE_LOW_RES: r = '{1'b1, 5'h0A, `ACR_MASK_PROCESSING_ENABLE_LOW_RES};
            `ACR_ADDR_BURST_MODE_PAIR_ENABLES: r = '{1'b1, 5'h0B, `ACR_MASK_BURST_MODE_PAIR_ENABLES};
            `ACR_ADDR_OVERRANGE_AND_GLOBAL_PD: r = '{1'b1, 5'h0C, `ACR_MASK_OVERRANGE_AND_GLOBAL_PD};
            `ACR_ADDR_FACTORY_SETTING_4A: r = '{1'b1, 5'h0D, `ACR_MASK_BIT0_ONLY};
            `ACR_ADDR_FACTORY_SETTING_62: r = '{1'b1, 5'h0E, `ACR_MASK_BIT0_ONLY};
            `ACR_ADDR_FACTORY_SETTING_7A: r = '{1'b1, 5'h0F, `ACR_MASK_BIT0_ONLY};
            `ACR_ADDR_FACTORY_SETTING_92: r = '{1'b1, 5'h10, `ACR_MASK_BIT0_ONLY};
            `ACR_ADDR_OUTPUT_CLOCK_DELAY_PAIR1: r = '{1'b1, 5'h11, `ACR_MASK_OUTPUT_CLOCK_DELAY_PAIR1};
            `ACR_ADDR_OUTPUT_CLOCK_DELAY_PAIR2: r = '{1'b1, 5'h12, `ACR_MASK_OUTPUT_CLOCK_DELAY_PAIR2};
            `ACR_ADDR_QUICK_OVERRANGE_LEVEL: r = '{1'b1, 5'h13, `ACR_MASK_FULL_BYTE};
            `ACR_ADDR_QUICK_OVERRANGE_ENABLE: r = '{1'b1, 5'h14, `ACR_MASK_BIT7_ONLY};
            `ACR_ADDR_FACTORY_SETTING_CF: r = '{1'b1, 5'h15, `ACR_MASK_FACTORY_SETTING_CF};
            `ACR_ADDR_FACTORY_SETTING_D4: r = '{1'b1, 5'h16, `ACR_MASK_BIT7_ONLY};
            `ACR_ADDR_FACTORY_SETTING_D5: r = '{1'b1, 5'h17, `ACR_MASK_BIT7_ONLY};
            `ACR_ADDR_FACTORY_SETTING_D6: r = '{1'b1, 5'h18, `ACR_MASK_BIT7_ONLY};
            `ACR_ADDR_FACTORY_SETTING_D7: r = '{1'b1, 5'h19, `ACR_MASK_FACTORY_SETTING_D7};
            `ACR_ADDR_FACTORY_SETTING_DB: r = '{1'b1, 5'h1A, `ACR_MASK_FACTORY_SETTING_DB};
            `ACR_ADDR_BOOST_PIN_OVERRIDE: r = '{1'b1, 5'h1B, `ACR_MASK_BIT7_ONLY};
            `ACR_ADDR_FACTORY_SETTING_F0: r = '{1'b1, 5'h1C, `ACR_MASK_FACTORY_SETTING_F0};
            `ACR_ADDR_DRIVE_LEVEL_UNLOCK: r = '{1'b1, 5'h1D, `ACR_MASK_DRIVE_LEVEL_UNLOCK};
            `ACR_ADDR_FACTORY_SETTING_F5: r = '{1'b1, 5'h1E, `ACR_MASK_FACTORY_SETTING_F5};
            `ACR_ADDR_PER_CHANNEL_POWER_DOWN: r = '{1'b1, 5'h1F, `ACR_MASK_PER_CHANNEL_POWER_DOWN};
            default: r = '{hit: 1'b0, slot: 5'h00, mask: 8'h00};
        endcase
        return r;
    endfunction

    localparam acr_lookup_s LK_CTRL = acr_lookup(`ACR_ADDR_SOFT_RESET_AND_READBACK);
    localparam acr_lookup_s LK_DRIVE = acr_lookup(`ACR_ADDR_OUTPUT_DRIVE_LEVEL);
    localparam acr_lookup_s LK_UNLOCK = acr_lookup(`ACR_ADDR_DRIVE_LEVEL_UNLOCK);
    localparam acr_lookup_s LK_PD = acr_lookup(`ACR_ADDR_PER_CHANNEL_POWER_DOWN);
    localparam acr_lookup_s LK_GPD = acr_lookup(`ACR_ADDR_OVERRANGE_AND_GLOBAL_PD);

    // Link domain: serial shifter, falling edge
    logic [3:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    acr_byte_t link_regs_reg [`ACR_NUM_SLOTS];
    acr_byte_t hold_addr_reg;
    acr_byte_t hold_data_reg;
    logic hold_toggle_reg;
    logic [6:0] out_shift_reg;
    logic serial_read_data_pin_reg;

    logic [15:0] word;
    acr_byte_t wr_addr;
    acr_byte_t wr_data;
    acr_lookup_s wr_lk;
    acr_lookup_s rd_lk;
    acr_byte_t rd_byte;
    logic commit;
    logic readback_on;
    logic wr_accept;
    logic wr_soft_reset;

    // Deselect clears the word position, so a partial word is dropped
    always_ff @(negedge link_sclk or posedge rst or posedge port_select_low) begin
        if (rst || port_select_low) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 15'h0000;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= {shift_reg[13:0], serial_write_data};
        end
    end

    assign word = {shift_reg, serial_write_data};
    assign wr_addr = word[15:8];
    assign wr_data = word[7:0];
    assign commit = (bit_cnt_reg == `ACR_CNT_LAST_BIT);
    assign wr_lk = acr_lookup(wr_addr);
    assign readback_on = link_regs_reg[LK_CTRL.slot][`ACR_BIT_READBACK];
    assign wr_accept = commit && wr_lk.hit
        && (!readback_on || wr_addr == `ACR_ADDR_SOFT_RESET_AND_READBACK);
    assign wr_soft_reset = wr_accept && wr_addr == `ACR_ADDR_SOFT_RESET_AND_READBACK
        && wr_data[`ACR_BIT_SOFT_RESET];

    // Link-side copy of the map, feeds readback without crossing
    generate
        for (genvar i = 0; i < `ACR_NUM_SLOTS; i++) begin : g_link_slot
            always_ff @(negedge link_sclk or posedge rst) begin
                if (rst) begin
                    link_regs_reg[i] <= `ACR_REG_RESET;
                end else if (wr_soft_reset) begin
                    link_regs_reg[i] <= `ACR_REG_RESET;
                end else if (wr_accept && wr_lk.slot == 5'(i)) begin
                    link_regs_reg[i] <= wr_data & wr_lk.mask;
                end
            end
        end
    endgenerate

    // Accepted word handed to the core domain; held stable for 16 bit times
    always_ff @(negedge link_sclk or posedge rst) begin
        if (rst) begin
            hold_addr_reg <= 8'h00;
            hold_data_reg <= 8'h00;
            hold_toggle_reg <= 1'b0;
        end else if (wr_accept) begin
            hold_addr_reg <= wr_addr;
            hold_data_reg <= wr_data;
            hold_toggle_reg <= ~hold_toggle_reg;
        end
    end

    always_ff @(negedge link_sclk or posedge rst) begin
        if (rst) begin
            serial_read_data_pin_oe <= 1'b0;
        end else begin
            // Follows the readback bit as it will stand after this edge
            if (wr_soft_reset) begin
                serial_read_data_pin_oe <= 1'b0;
            end else if (wr_accept && wr_addr == `ACR_ADDR_SOFT_RESET_AND_READBACK) begin
                serial_read_data_pin_oe <= wr_data[`ACR_BIT_READBACK];
            end
        end
    end

    // Link domain: read data, rising edge
    assign rd_lk = acr_lookup(shift_reg[7:0]);
    assign rd_byte = (rd_lk.hit && rd_lk.slot != LK_CTRL.slot) ? link_regs_reg[rd_lk.slot] : 8'h00;

    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            serial_read_data_pin_reg <= 1'b0;
            out_shift_reg <= 7'h00;
        end else if (bit_cnt_reg == `ACR_CNT_READ_START) begin
            serial_read_data_pin_reg <= rd_byte[7];
            out_shift_reg <= rd_byte[6:0];
        end else begin
            serial_read_data_pin_reg <= out_shift_reg[6];
            out_shift_reg <= {out_shift_reg[5:0], 1'b0};
        end
    end

    assign serial_read_data_pin = serial_read_data_pin_reg;

    // Core domain: toggle handshake and outputs
    logic tog_sync1_reg;
    logic tog_sync2_reg;
    logic tog_seen_reg;
    logic apply;
    logic core_soft_reset;
    acr_lookup_s core_lk;
    acr_byte_t core_regs_reg [`ACR_NUM_SLOTS];
    logic [5:0] drive_sel_next;
    acr_mv_t drive_mv_next;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tog_sync1_reg <= 1'b0;
            tog_sync2_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_sync1_reg <= hold_toggle_reg;
            tog_sync2_reg <= tog_sync1_reg;
            tog_seen_reg <= tog_sync2_reg;
        end
    end

    assign apply = tog_sync2_reg ^ tog_seen_reg;
    assign core_lk = acr_lookup(hold_addr_reg);
    assign core_soft_reset = apply && hold_addr_reg == `ACR_ADDR_SOFT_RESET_AND_READBACK
        && hold_data_reg[`ACR_BIT_SOFT_RESET];

    generate
        for (genvar j = 0; j < `ACR_NUM_SLOTS; j++) begin : g_core_slot
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    core_regs_reg[j] <= `ACR_REG_RESET;
                end else if (core_soft_reset) begin
                    core_regs_reg[j] <= `ACR_REG_RESET;
                end else if (apply && core_lk.slot == 5'(j)) begin
                    core_regs_reg[j] <= hold_data_reg & core_lk.mask;
                end
            end
        end
    endgenerate

    // Field applies only once unlocked, else default level
    always_comb begin
        drive_sel_next = `ACR_SWING_DEFAULT;
        if (core_regs_reg[LK_UNLOCK.slot][`ACR_UNLOCK_MSB:`ACR_UNLOCK_LSB] == `ACR_UNLOCK_KEY) begin
            drive_sel_next = core_regs_reg[LK_DRIVE.slot][`ACR_SWING_MSB:`ACR_SWING_LSB];
        end
        case (drive_sel_next)
            ACR_SWING_420: drive_mv_next = `ACR_MV_420;
            ACR_SWING_470: drive_mv_next = `ACR_MV_470;
            ACR_SWING_560: drive_mv_next = `ACR_MV_560;
            ACR_SWING_160: drive_mv_next = `ACR_MV_160;
            default: drive_mv_next = `ACR_MV_350;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drive_level_sel <= `ACR_SWING_DEFAULT;
            drive_level_mv <= `ACR_MV_350;
            chan_power_down <= 4'h0;
            global_power_down <= 1'b0;
            readback_active <= 1'b0;
        end else begin
            drive_level_sel <= drive_sel_next;
            drive_level_mv <= drive_mv_next;
            chan_power_down <= core_regs_reg[LK_PD.slot][`ACR_PDN_MSB:`ACR_PDN_LSB];
            global_power_down <= core_regs_reg[LK_GPD.slot][`ACR_GLOBAL_PDN_BIT];
            readback_active <= core_regs_reg[LK_CTRL.slot][`ACR_BIT_READBACK];
        end
    end
endmodule

// ---- verif/acr_host_model.sv ----
// Host model driving the four-wire serial port.
// Assumes the bench calls frame() just after a core clock edge.
`timescale 1ns/1ps
module acr_host_model (
    output logic link_sclk,
    output logic port_select_low,
    output logic serial_write_data,
    input wire logic serial_read_data_pin,
    input wire logic serial_read_data_pin_oe
);
    wire serial_read_data_pin_wire;
    assign serial_read_data_pin_wire = serial_read_data_pin_oe ? serial_read_data_pin : 1'bz;
    initial begin
        link_sclk = 1'b0;
        port_select_low = 1'b1;
        serial_write_data = 1'b0;
    end
    // Clock runs only inside a frame, 12 ns period
    task automatic frame(input logic [31:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        port_select_low = 1'b0;
        for (int k = 0; k < n; k++) begin
            serial_write_data = w[31 - (k % 32)];
            #5 link_sclk = 1'b1;
            #6 link_sclk = 1'b0;
            if (k >= 8 && k < 16) rd = {rd[6:0], serial_read_data_pin_wire};
            #1;
        end
        port_select_low = 1'b1;
        serial_write_data = ~serial_write_data;
    endtask
endmodule

// ---- verif/acr_config_regs_monitor.sv ----
// Port checker for the configuration register bank.
// Assumes binding onto acr_config_regs, sampling on the core clock.
`timescale 1ns/1ps
module acr_config_regs_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_sclk,
    input wire logic port_select_low,
    input wire logic serial_write_data,
    input wire logic serial_read_data_pin,
    input wire logic serial_read_data_pin_oe,
    input wire logic readback_active,
    input wire logic [5:0] drive_level_sel,
    input wire acr_pkg::acr_mv_t drive_level_mv,
    input wire logic [3:0] chan_power_down,
    input wire logic global_power_down
);
    import acr_pkg::*;
    logic [3:0] idle_cnt_reg;
    acr_mv_t mv_exp;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Core cycles since select went high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) idle_cnt_reg <= 4'h0;
        else if (!port_select_low) idle_cnt_reg <= 4'h0;
        else if (idle_cnt_reg != 4'hF) idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
    always_comb begin
        case (drive_level_sel)
            6'h1B: mv_exp = 10'h1A4;
            6'h32: mv_exp = 10'h1D6;
            6'h14: mv_exp = 10'h230;
            6'h0F: mv_exp = 10'h0A0;
            default: mv_exp = 10'h15E;
        endcase
    end
    sequence s_rb_steady;
        readback_active ##1 readback_active;
    endsequence
    a_oe_rb_on: assert property ($rose(readback_active) |-> serial_read_data_pin_oe)
        else $error("read pin not driven with readback on");
    a_oe_rb_off: assert property ($fell(readback_active) |-> !serial_read_data_pin_oe)
        else $error("read pin driven with readback off");
    a_oe_idle_sel: assert property (port_select_low && $past(port_select_low) |-> $stable(serial_read_data_pin_oe))
        else $error("read enable moved while deselected");
    a_mv_decode: assert property (drive_level_mv == mv_exp)
        else $error("drive level decode wrong");
    a_out_idle: assert property (idle_cnt_reg > 4'h8 |->
        $stable(chan_power_down) && $stable(global_power_down) && $stable(drive_level_sel))
        else $error("outputs moved without a word");
    a_serial_read_data_pin_rise: assert property ($changed(serial_read_data_pin) |-> $rose(link_sclk))
        else $error("read data changed off a rising edge");
    a_pd_hold_rb: assert property (s_rb_steady |-> $stable(chan_power_down) && $stable(global_power_down))
        else $error("power down written during readback");
    a_sel_hold_rb: assert property (s_rb_steady |-> $stable(drive_level_sel))
        else $error("drive level written during readback");
endmodule
bind acr_config_regs acr_config_regs_monitor mon_u (.core_clk(core_clk), .rst(rst), .link_sclk(link_sclk),
    .port_select_low(port_select_low), .serial_write_data(serial_write_data),
    .serial_read_data_pin(serial_read_data_pin), .serial_read_data_pin_oe(serial_read_data_pin_oe),
    .readback_active(readback_active), .drive_level_sel(drive_level_sel), .drive_level_mv(drive_level_mv),
    .chan_power_down(chan_power_down), .global_power_down(global_power_down));

// ---- verif/tb_top.sv ----
// Self-checking bench for the configuration register bank.
// Assumes acr_host_model drives the serial port and a byte-array model predicts results.
`timescale 1ns/1ps
module tb_top;
    import acr_pkg::*;
    logic core_clk, rst, link_sclk, port_select_low, serial_write_data;
    logic serial_read_data_pin, serial_read_data_pin_oe, readback_active, global_power_down;
    logic [5:0] drive_level_sel;
    acr_mv_t drive_level_mv;
    logic [3:0] chan_power_down;
    int fail_count, n_tests;
    logic [31:0] lfsr;
    logic [7:0] mdl [256];
    logic [7:0] rd;
    logic [5:0] codes [5] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h0F};
    logic [7:0] raddr [8] = '{8'h01, 8'hF1, 8'hFE, 8'h45, 8'h3D, 8'h25, 8'h02, 8'h00};
    acr_config_regs dut_u (.core_clk(core_clk), .rst(rst), .link_sclk(link_sclk),
        .port_select_low(port_select_low), .serial_write_data(serial_write_data),
        .serial_read_data_pin(serial_read_data_pin), .serial_read_data_pin_oe(serial_read_data_pin_oe),
        .readback_active(readback_active), .drive_level_sel(drive_level_sel), .drive_level_mv(drive_level_mv),
        .chan_power_down(chan_power_down), .global_power_down(global_power_down));
    acr_host_model host_u (.link_sclk(link_sclk), .port_select_low(port_select_low),
        .serial_write_data(serial_write_data), .serial_read_data_pin(serial_read_data_pin),
        .serial_read_data_pin_oe(serial_read_data_pin_oe));
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            8'h00: return 8'h01;
            8'h01: return 8'hFC;
            8'h25: return 8'hFF;
            8'h3D: return 8'h20;
            8'h45: return 8'h0D;
            8'hF1: return 8'h23;
            8'hFE: return 8'h0F;
            default: return 8'h00;
        endcase
    endfunction
    function automatic acr_mv_t mv_of(input logic [5:0] c);
        case (c)
            6'h1B: return 10'h1A4;
            6'h32: return 10'h1D6;
            6'h14: return 10'h230;
            6'h0F: return 10'h0A0;
            default: return 10'h15E;
        endcase
    endfunction
    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apply(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h00 && d[1]) foreach (mdl[i]) mdl[i] = 8'h00;
        else if (a == 8'h00) mdl[0] = d & 8'h01;
        else if (!mdl[0][0]) mdl[a] = d & mask_of(a);
    endtask
    task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] r);
        @(posedge core_clk);
        #1;
        host_u.frame(w, n, r);
        if (n >= 16) apply(w[31:24], w[23:16]);
        if (n >= 32) apply(w[15:8], w[7:0]);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic check_outs();
        logic [5:0] sel;
        sel = (mdl[8'hF1][1:0] == 2'h3) ? mdl[1][7:2] : 6'h00;
        check(readback_active, mdl[0][0]);
        check(serial_read_data_pin_oe, mdl[0][0]);
        check(drive_level_sel, sel);
        check(drive_level_mv, mv_of(sel));
        check(chan_power_down, mdl[8'hFE][3:0]);
        check(global_power_down, mdl[8'h45][2]);
    endtask
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        lfsr = 32'h28B2;
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        check_outs();
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            xfer({8'h01, codes[i], lfsr[1:0], 16'h0000}, 16, rd);
            check_outs();
            xfer({8'hF1, 8'h23, 16'h0000}, 16, rd);
            check_outs();
            xfer({8'hF1, 8'h02, 16'h0000}, 16, rd);
            check_outs();
        end
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            xfer({8'hFE, lfsr[7:0], 8'h45, lfsr[15:8]}, 32, rd);
            check_outs();
        end
        xfer({8'hFE, ~mdl[8'hFE], 16'h0000}, 8, rd);
        check_outs();
        xfer({8'hFE, ~mdl[8'hFE], 8'hFF, 8'hFF}, 21, rd);
        check_outs();
        xfer({8'h3D, 8'hFF, 16'h0000}, 16, rd);
        xfer({8'h25, lfsr[23:16], 16'h0000}, 16, rd);
        xfer({8'h00, 8'h01, 16'h0000}, 16, rd);
        check_outs();
        xfer({8'hFE, ~mdl[8'hFE], 16'h0000}, 16, rd);
        check_outs();
        foreach (raddr[i]) begin
            lfsr = lfsr_next(lfsr);
            xfer({raddr[i], (raddr[i] == 8'h00) ? 8'h01 : lfsr[7:0], 16'h0000}, 16, rd);
            check(rd, (raddr[i] == 8'h00) ? 8'h00 : mdl[raddr[i]]);
        end
        xfer({8'h00, 8'h00, 16'h0000}, 16, rd);
        check_outs();
        xfer({8'hFE, 8'h0F, 16'h0000}, 16, rd);
        check_outs();
        xfer({8'h00, 8'h02, 16'h0000}, 16, rd);
        check_outs();
        xfer({8'h00, 8'h01, 16'h0000}, 16, rd);
        xfer({8'hFE, 8'h00, 16'h0000}, 16, rd);
        check(rd, 8'h00);
        #1 rst = 1'b1;
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        check_outs();
        test_done();
    end
endmodule
